// [hcp_pkg.sv]
// Package for the referencing and cyclic position mode block.
package hcp_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_METHOD = 8'h08;
  localparam logic [7:0] ADDR_BLK_CUR = 8'h0C;
  localparam logic [7:0] ADDR_BLK_MS = 8'h10;
  localparam logic [7:0] ADDR_IP_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_IP_BUFCFG = 8'h18;
  localparam logic [7:0] ADDR_TARGET = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_POS = 8'h24;
  localparam logic [7:0] ADDR_CFG = 8'h28;
  localparam logic [7:0] ADDR_FERR_WIN = 8'h2C;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CW_START = 4;
  localparam int CW_HALT = 8;
  localparam int SW_SYNC = 8;
  localparam int SW_REACHED = 10;
  localparam int SW_B12 = 12;
  localparam int SW_B13 = 13;
  localparam int CFG_CLOSED_LOOP = 0;
  localparam int CFG_OP_ENABLED = 1;
  localparam int CFG_NMT_OPER = 2;

  // ==========================================================================
  // Mode codes and reset values
  // ==========================================================================
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_IP = 8'h07;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_METHOD = 8'h23;
  localparam logic [15:0] RST_BLK_CUR = 16'h0100;
  localparam logic [15:0] RST_BLK_MS = 16'h000A;
  localparam logic [15:0] RST_IP_PERIOD = 16'h0001;
  localparam logic [31:0] RST_FERR_WIN = 32'h0000_0100;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ = 250;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [5:0] {
    HS_IDLE = 6'b000001,
    HS_SEEK = 6'b000010,
    HS_PUSH = 6'b000100,
    HS_INDEX = 6'b001000,
    HS_DONE = 6'b010000,
    HS_ERROR = 6'b100000
  } hcp_hstate_t;

  typedef struct packed {
    logic use_index;
    logic use_limit;
    logic use_home;
    logic positive;
    logic right_edge;
    logic index_only;
    logic current_pos;
    logic valid;
  } hcp_method_t;

  typedef struct packed {
    logic neg_limit;
    logic pos_limit;
    logic home_sw;
    logic index;
  } hcp_sensors_t;

endpackage : hcp_pkg

// [hcp_motion.sv]
// Referencing, interpolated position and cyclic position mode logic.
`timescale 1ns/1ns
module hcp_motion
  import hcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hcp_sensors_t sensors,
  input wire logic [15:0] motor_current,
  input wire logic sync_pulse,
  output logic [31:0] pos_demand,
  output logic move_active,
  output logic move_dir_pos
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic hcp_method_t decode_method(input logic [7:0] m);
    hcp_method_t d;
    logic [7:0] b;
    d = '0;
    b = (m >= 8'd17 && m <= 8'd30) ? m - 8'd16 : m;
    if (b >= 8'd1 && b <= 8'd14) begin
      d.valid = 1'b1;
      d.use_index = (m <= 8'd14);
      unique case (b)
        8'd1, 8'd2: begin
          d.use_limit = 1'b1;
          d.positive = (b == 8'd2);
        end
        8'd3, 8'd4, 8'd5, 8'd6: begin
          d.use_home = 1'b1;
          d.right_edge = (b >= 8'd5);
          d.positive = b[0];
        end
        default: begin
          d.use_home = 1'b1;
          d.positive = (b <= 8'd10);
          d.right_edge = b[0];
        end
      endcase
    end else if (m == 8'd33 || m == 8'd34) begin
      d.valid = 1'b1;
      d.use_index = 1'b1;
      d.index_only = 1'b1;
      d.positive = (m == 8'd34);
    end else if (m == 8'd35) begin
      d.valid = 1'b1;
      d.current_pos = 1'b1;
    end
    return d;
  endfunction : decode_method

  function automatic logic [31:0] step_toward(input logic [31:0] cur,
                                              input logic [31:0] tgt,
                                              input logic [31:0] stp);
    logic [31:0] diff;
    diff = tgt - cur;
    if (diff[31]) begin
      step_toward = ((cur - tgt) > stp) ? cur - stp : tgt;
    end else begin
      step_toward = (diff > stp) ? cur + stp : tgt;
    end
  endfunction : step_toward

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] mode, method_raw;
  logic [15:0] ctrl, blk_cur, blk_ms, ip_period, status, push_ms;
  logic [31:0] target, ferr_win, pos, ip_step;
  logic [2:0] cfg;
  logic [17:0] ms_cnt;
  logic method_neg, ip_bufcfg, ms_tick, synced, ferr;
  logic wr, rd, start, halt, valid_addr;
  hcp_hstate_t hstate;
  hcp_method_t meth;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign start = ctrl[CW_START];
  assign halt = ctrl[CW_HALT];
  assign meth = decode_method(method_raw);

  // ==========================================================================
  // APB slave: zero-wait writes, read data latched in the setup cycle
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > ADDR_FERR_WIN || paddr[1:0] != 2'b00);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd) begin
      unique case (paddr)
        ADDR_MODE: prdata <= {24'h0, mode};
        ADDR_CTRL: prdata <= {16'h0, ctrl};
        ADDR_METHOD: prdata <= {{24{method_neg}}, method_neg ? -method_raw : method_raw};
        ADDR_BLK_CUR: prdata <= {16'h0, blk_cur};
        ADDR_BLK_MS: prdata <= {16'h0, blk_ms};
        ADDR_IP_PERIOD: prdata <= {16'h0, ip_period};
        ADDR_IP_BUFCFG: prdata <= {31'h0, ip_bufcfg};
        ADDR_TARGET: prdata <= target;
        ADDR_STATUS: prdata <= {16'h0, status};
        ADDR_POS: prdata <= pos;
        ADDR_CFG: prdata <= {29'h0, cfg};
        ADDR_FERR_WIN: prdata <= ferr_win;
        default: prdata <= '0;
      endcase
    end
  end

  assign valid_addr = (paddr <= ADDR_FERR_WIN) && (paddr[1:0] == 2'b00);

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= RST_MODE;
      ctrl <= '0;
      blk_cur <= RST_BLK_CUR;
      blk_ms <= RST_BLK_MS;
      ip_period <= RST_IP_PERIOD;
      ip_bufcfg <= 1'b0;
      cfg <= '0;
      ferr_win <= RST_FERR_WIN;
    end else if (wr && valid_addr) begin
      unique case (paddr)
        ADDR_MODE: mode <= pwdata[7:0];
        ADDR_CTRL: ctrl <= pwdata[15:0];
        ADDR_BLK_CUR: blk_cur <= pwdata[15:0];
        ADDR_BLK_MS: blk_ms <= pwdata[15:0];
        ADDR_IP_PERIOD: ip_period <= (pwdata[15:0] == 16'h0) ? 16'h0001 : pwdata[15:0];
        ADDR_IP_BUFCFG: ip_bufcfg <= (pwdata == 32'h0000_0001);
        ADDR_CFG: cfg <= pwdata[2:0];
        ADDR_FERR_WIN: ferr_win <= pwdata;
        default: ;
      endcase
    end
  end

  // Method write: a negative value selects block detection; unknown ignored.
  logic [7:0] wr_mag;
  assign wr_mag = pwdata[31] ? 8'(-pwdata[7:0]) : pwdata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      method_raw <= RST_METHOD;
      method_neg <= 1'b0;
    end else if (wr && paddr == ADDR_METHOD && decode_method(wr_mag).valid
                 && hstate != HS_SEEK && hstate != HS_PUSH
                 && hstate != HS_INDEX) begin
      method_raw <= wr_mag;
      method_neg <= pwdata[31];
    end
  end

  // Target writes: in mode 7 only with buffer configuration set.
  always_ff @(posedge clk) begin
    if (rst) begin
      target <= '0;
    end else if (wr && paddr == ADDR_TARGET) begin
      if (mode != MODE_IP || ip_bufcfg) begin
        target <= pwdata;
      end
    end
  end

  // ==========================================================================
  // Millisecond enable
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 18'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == 18'(MS_CYCLES - 1)) ? '0 : ms_cnt + 18'd1;
    end
  end

  // ==========================================================================
  // Referencing sequencer
  // ==========================================================================
  logic limit_hit, edge_hit, home_prev, blk_hit;
  assign blk_hit = motor_current > blk_cur;
  assign limit_hit = method_neg ? blk_hit :
                     (meth.positive ? sensors.pos_limit : sensors.neg_limit);
  // Left edge is met moving right as a rise; right edge as a fall.
  assign edge_hit = meth.right_edge ? (home_prev && !sensors.home_sw)
                                    : (!home_prev && sensors.home_sw);

  always_ff @(posedge clk) begin
    if (rst) begin
      home_prev <= 1'b0;
    end else begin
      home_prev <= sensors.home_sw;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hstate <= HS_IDLE;
      push_ms <= '0;
    end else if (mode != MODE_HOMING || !start) begin
      hstate <= HS_IDLE;
    end else begin
      unique case (hstate)
        HS_IDLE: begin
          if (method_neg && !cfg[CFG_CLOSED_LOOP]) begin
            hstate <= HS_ERROR;
          end else if (meth.current_pos) begin
            hstate <= HS_DONE;
          end else if (!cfg[CFG_OP_ENABLED]) begin
            hstate <= HS_ERROR;
          end else if (meth.index_only) begin
            hstate <= HS_INDEX;
          end else begin
            hstate <= HS_SEEK;
          end
        end
        HS_SEEK: begin
          if (meth.use_limit && limit_hit) begin
            push_ms <= blk_ms;
            hstate <= method_neg ? HS_PUSH :
                      (meth.use_index ? HS_INDEX : HS_DONE);
          end else if (meth.use_home && edge_hit) begin
            hstate <= meth.use_index ? HS_INDEX : HS_DONE;
          end
        end
        HS_PUSH: begin
          if (push_ms == '0) begin
            hstate <= meth.use_index ? HS_INDEX : HS_DONE;
          end else if (ms_tick) begin
            push_ms <= push_ms - 16'd1;
          end
        end
        HS_INDEX: begin
          if (sensors.index) begin
            hstate <= HS_DONE;
          end
        end
        HS_DONE, HS_ERROR: ;
      endcase
    end
  end

  // Direction flips once after hitting either limit switch so that the edge is
  // found from whichever side the axis started.
  logic dir_rev;
  always_ff @(posedge clk) begin
    if (rst || hstate == HS_IDLE) begin
      dir_rev <= 1'b0;
    end else if (hstate == HS_SEEK && meth.use_home
                 && (sensors.pos_limit || sensors.neg_limit)) begin
      dir_rev <= 1'b1;
    end
  end

  // ==========================================================================
  // Interpolation, sync and following error
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      synced <= 1'b0;
    end else if (!cfg[CFG_NMT_OPER]) begin
      synced <= 1'b0;
    end else if (sync_pulse) begin
      synced <= 1'b1;
    end
  end

  logic ip_active;
  assign ip_active = (mode == MODE_IP) && start && synced;

  always_ff @(posedge clk) begin
    if (rst) begin
      ip_step <= '0;
    end else if (sync_pulse || target == pos) begin
      ip_step <= ((target - pos) & 32'h8000_0000) != 0 ?
                 (pos - target) / {16'h0, ip_period} + 32'd1 :
                 (target - pos) / {16'h0, ip_period} + 32'd1;
    end
  end

  logic [31:0] ferr_abs;
  assign ferr_abs = (target - pos) >= 32'h8000_0000 ? pos - target
                  : target - pos;

  always_ff @(posedge clk) begin
    if (rst) begin
      ferr <= 1'b0;
    end else begin
      ferr <= (mode == MODE_CSP) && synced && !halt && (ferr_abs > ferr_win);
    end
  end

  // Position: linear path in mode 7, direct absolute preset in mode 8.
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= '0;
    end else if (mode == MODE_HOMING && hstate == HS_DONE) begin
      pos <= '0;
    end else if (halt) begin
      pos <= pos;
    end else if (ip_active && ms_tick) begin
      pos <= step_toward(pos, target, ip_step);
    end else if (mode == MODE_CSP && synced && sync_pulse) begin
      pos <= target;
    end
  end

  // ==========================================================================
  // Status and motion outputs
  // ==========================================================================
  logic [15:0] next_status;
  always_comb begin
    next_status = '0;
    unique case (mode)
      MODE_HOMING: begin
        unique case (hstate)
          HS_IDLE: next_status[SW_REACHED] = 1'b1;
          HS_DONE: {next_status[SW_B12], next_status[SW_REACHED]} = 2'b11;
          HS_ERROR: {next_status[SW_B13], next_status[SW_REACHED]} = 2'b11;
          default: ;
        endcase
      end
      MODE_IP: begin
        next_status[SW_B12] = ip_active;
        next_status[SW_REACHED] = halt ? !move_active : (pos == target);
      end
      MODE_CSP: begin
        next_status[SW_SYNC] = synced;
        next_status[SW_B12] = synced && !halt;
        next_status[SW_B13] = ferr;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
      pos_demand <= '0;
      move_active <= 1'b0;
      move_dir_pos <= 1'b0;
    end else begin
      status <= next_status;
      pos_demand <= pos;
      move_active <= !halt && ((mode == MODE_HOMING && (hstate == HS_SEEK
                     || hstate == HS_PUSH || hstate == HS_INDEX))
                     || (ip_active && pos != target));
      move_dir_pos <= (mode == MODE_HOMING) ? (meth.positive ^ dir_rev)
                      : (target > pos);
    end
  end

endmodule : hcp_motion

// [hcp_axis_model.sv]
// Axis and network model: switches, index pulse, motor current and sync.
`timescale 1ns/1ns
module hcp_axis_model
  import hcp_pkg::*;
#(
  parameter int SYNC_CYC = 40
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_en,
  input wire logic index_req,
  input wire hcp_sensors_t sw_level,
  input wire logic [15:0] cur_level,
  output hcp_sensors_t sensors,
  output logic [15:0] motor_current,
  output logic sync_pulse
);
  int cnt;
  // ======
  // Sync messages at a fixed interval, silent while disabled.
  // ======
  always_ff @(posedge clk) begin
    if (rst || !sync_en) begin
      cnt <= 0;
      sync_pulse <= 1'h0;
    end else begin
      cnt <= (cnt == SYNC_CYC - 1) ? 0 : cnt + 1;
      sync_pulse <= (cnt == SYNC_CYC - 1);
    end
  end
  always_ff @(posedge clk) begin
    sensors <= {sw_level[3:1], index_req};
    motor_current <= cur_level;
  end
endmodule : hcp_axis_model

// [hcp_motion_checker.sv]
// Assertion checker for the motion mode block and its bind.
`timescale 1ns/1ns
module hcp_motion_checker
  import hcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire hcp_sensors_t sensors,
  input wire logic [15:0] motor_current,
  input wire logic sync_pulse,
  input wire logic [31:0] pos_demand,
  input wire logic move_active,
  input wire logic move_dir_pos
);
  logic [7:0] mode_sh;
  logic [31:0] cw_sh;
  logic [2:0] cfg_sh;
  logic [31:0] tgt_sh;
  logic wr_ok;
  logic csp_run;
  logic buf_sh;
  logic sync_sh;
  logic [31:0] tgt_sync;
  // ======
  // Shadow of the registers that gate cyclic following.
  // ======
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign csp_run = mode_sh == MODE_CSP && !cw_sh[CW_HALT] && sync_sh;
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_sh <= RST_MODE;
      cw_sh <= 32'h0;
      cfg_sh <= 3'h0;
      tgt_sh <= 32'h0;
      buf_sh <= 1'h0;
    end else if (wr_ok) begin
      if (paddr == ADDR_MODE) mode_sh <= pwdata[7:0];
      if (paddr == ADDR_CTRL) cw_sh <= pwdata;
      if (paddr == ADDR_CFG) cfg_sh <= pwdata[2:0];
      if (paddr == ADDR_IP_BUFCFG) buf_sh <= pwdata == 32'h1;
      if (paddr == ADDR_TARGET && (mode_sh != MODE_IP || buf_sh))
        tgt_sh <= pwdata;
    end
  end
  // The preset is captured at the sync so that a later write cannot race it.
  always_ff @(posedge clk) begin
    if (rst || !cfg_sh[CFG_NMT_OPER]) sync_sh <= 1'h0;
    else if (sync_pulse) sync_sh <= 1'h1;
    if (sync_pulse) tgt_sync <= tgt_sh;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_csp_sync;
    csp_run && sync_pulse;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready && (paddr > ADDR_FERR_WIN ||
    paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= ADDR_FERR_WIN &&
    paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  a_reset_quiet: assert property ($fell(rst) |->
    pos_demand == 32'h0 && !move_active && !pready)
    else $error("outputs not cleared by reset");
  a_csp_follow: assert property (s_csp_sync |-> ##[1:4] pos_demand == tgt_sync)
    else $error("cyclic preset not taken after sync");
  a_csp_hold: assert property ((mode_sh == MODE_CSP && !cw_sh[CW_HALT] &&
    !sync_pulse)[*6] |-> $stable(pos_demand))
    else $error("position moved without sync");
endmodule : hcp_motion_checker
bind hcp_motion hcp_motion_checker u_chk (.clk(clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sensors(sensors), .motor_current(motor_current),
  .sync_pulse(sync_pulse), .pos_demand(pos_demand),
  .move_active(move_active), .move_dir_pos(move_dir_pos));

// [hcp_motion_tb.sv]
// Self-checking testbench for the motion mode block.
`timescale 1ns/1ns
module hcp_motion_tb;
  import hcp_pkg::*;
  typedef struct {
    string name;
    logic [31:0] mask;
    logic [32:0] exp;
  } hcp_note_t;
  localparam logic [31:0] HM = 32'h0000_3400;
  logic clk = 1'h0;
  logic rst, psel, penable, pwrite, pready, pslverr, sync_pulse;
  logic move_active, move_dir_pos, sync_en, index_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pos_demand, rd, seed, t, u, p;
  logic [15:0] motor_current, cur_level;
  hcp_sensors_t sensors, sw_level;
  int mismatches, total_checks, di;
  hcp_note_t notes[$];
  always #2 clk = ~clk;
  hcp_motion u_hcp_motion (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sensors(sensors),
    .motor_current(motor_current), .sync_pulse(sync_pulse),
    .pos_demand(pos_demand), .move_active(move_active),
    .move_dir_pos(move_dir_pos));
  hcp_axis_model #(.SYNC_CYC(40)) u_hcp_axis_model (.clk(clk), .rst(rst),
    .sync_en(sync_en), .index_req(index_req), .sw_level(sw_level),
    .cur_level(cur_level), .sensors(sensors), .motor_current(motor_current),
    .sync_pulse(sync_pulse));
  // ======
  // Helpers.
  // ======
  function automatic logic [31:0] rand32();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rand32
  task automatic check(input string n, input logic [32:0] e,
      input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Reads queue a note; a zero mask marks a poll that is not compared.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input string n, input logic [31:0] m, input logic [32:0] e);
    if (!w) notes.push_back('{n, m, e});
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, "", 32'h0, 33'h0);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0, n, m, {1'h0, e & m});
  endtask : rdc
  task automatic wait_reg(input string n, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 100; i++) begin
      apb(1'h0, a, 32'h0, "", 32'h0, 33'h0);
      if ((rd & m) === v) break;
    end
    rdc(n, a, m, v);
  endtask : wait_reg
  task automatic home(input logic [31:0] m, input logic [31:0] cfg);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, cfg);
    wr(ADDR_METHOD, m);
    wr(ADDR_CTRL, 32'h10);
  endtask : home
  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && notes.size() > 0)
    begin
      hcp_note_t n;
      n = notes.pop_front();
      if (n.mask !== 32'h0) check(n.name, n.exp, {pslverr, prdata & n.mask});
    end
  end
  initial begin
    #(4 * 60000);
    mismatches++;
    tally_and_finish();
  end
  // ======
  // Scenarios.
  // ======
  initial begin
    mismatches = 0;
    total_checks = 0;
    seed = 32'h44F8_1E5C;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sync_en = 1'h0;
    index_req = 1'h0;
    sw_level = '0;
    cur_level = 16'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdc("mode", ADDR_MODE, 32'hFF, RST_MODE);
    rdc("blk cur", ADDR_BLK_CUR, 32'hFFFF, RST_BLK_CUR);
    rdc("blk ms", ADDR_BLK_MS, 32'hFFFF, RST_BLK_MS);
    rdc("period", ADDR_IP_PERIOD, 32'hFFFF, RST_IP_PERIOD);
    rdc("ferr win", ADDR_FERR_WIN, 32'hFFFF_FFFF, RST_FERR_WIN);
    wr(8'h30, 32'hFFFF_FFFF);
    apb(1'h0, 8'h30, 32'h0, "unmapped", 32'hFFFF_FFFF, {1'h1, 32'h0});
    apb(1'h0, 8'h06, 32'h0, "unaligned", 32'hFFFF_FFFF, {1'h1, 32'h0});
    u = {24'h0, RST_METHOD};
    for (int m = 0; m <= 36; m++) begin
      if (m inside {[1:14], [17:30], [33:35]}) u = m;
      wr(ADDR_METHOD, m);
      rdc("method", ADDR_METHOD, 32'hFF, u);
    end
    $display("test registers done");
    wr(ADDR_MODE, MODE_HOMING);
    rdc("idle", ADDR_STATUS, HM, 32'h0400);
    home(35, 32'h0);
    wait_reg("current pos done", ADDR_STATUS, HM, 32'h1400);
    check("m35 still", 33'h0, {32'h0, move_active});
    home(33, 32'h2);
    wait_reg("index run", ADDR_STATUS, HM, 32'h0);
    wr(ADDR_METHOD, 32'h1);
    rdc("method locked", ADDR_METHOD, 32'hFF, 32'h21);
    index_req <= 1'h1;
    @(posedge clk);
    index_req <= 1'h0;
    wait_reg("index done", ADDR_STATUS, HM, 32'h1400);
    for (int i = 0; i < 2; i++) begin
      home(17 + i, 32'h2);
      wait_reg("limit run", ADDR_STATUS, HM, 32'h0);
      check("limit dir", {32'h0, i[0]}, {32'h0, move_dir_pos});
      if (i == 0) sw_level.neg_limit <= 1'h1;
      else sw_level.pos_limit <= 1'h1;
      repeat (20) @(posedge clk);
      sw_level <= '0;
      wait_reg("limit done", ADDR_STATUS, HM, 32'h1400);
    end
    home(-17, 32'h2);
    wait_reg("block open loop", ADDR_STATUS, HM, 32'h2400);
    t = rand32();
    t = {17'h0, t[14:0]};
    wr(ADDR_BLK_CUR, t);
    wr(ADDR_BLK_MS, 32'h0);
    cur_level <= t[15:0];
    home(-17, 32'h3);
    wait_reg("block run", ADDR_STATUS, HM, 32'h0);
    repeat (20) @(posedge clk);
    rdc("at threshold", ADDR_STATUS, HM, 32'h0);
    cur_level <= t[15:0] + 16'h1;
    wait_reg("block done", ADDR_STATUS, HM, 32'h1400);
    cur_level <= 16'h0;
    $display("test referencing done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h6);
    wr(ADDR_MODE, MODE_IP);
    sync_en <= 1'h1;
    wr(ADDR_IP_BUFCFG, 32'h0);
    apb(1'h0, ADDR_TARGET, 32'h0, "", 32'h0, 33'h0);
    u = rd;
    t = rand32();
    wr(ADDR_TARGET, t);
    rdc("target locked", ADDR_TARGET, 32'hFFFF_FFFF, u);
    wr(ADDR_IP_BUFCFG, 32'h1);
    wr(ADDR_TARGET, t);
    rdc("target open", ADDR_TARGET, 32'hFFFF_FFFF, t);
    rdc("ip inactive", ADDR_STATUS, 32'h1000, 32'h0);
    wr(ADDR_CTRL, 32'h10);
    wait_reg("ip active", ADDR_STATUS, 32'h1000, 32'h1000);
    wr(ADDR_CTRL, 32'h0);
    wait_reg("ip stopped", ADDR_STATUS, 32'h1000, 32'h0);
    rdc("ip not reached", ADDR_STATUS, 32'h0400, 32'h0);
    wr(ADDR_CTRL, 32'h100);
    rdc("ip halted", ADDR_STATUS, 32'h0400, 32'h0400);
    check("ip halt still", 33'h0, {32'h0, move_active});
    wr(ADDR_CTRL, 32'h0);
    $display("test interpolation done");
    wr(ADDR_MODE, MODE_CSP);
    wait_reg("csp sync", ADDR_STATUS, 32'h0100, 32'h0100);
    sync_en <= 1'h0;
    repeat (8) @(posedge clk);
    p = pos_demand;
    t = rand32() & 32'h00FF_FFFF;
    u = rand32() & 32'h00FF_FFFF;
    wr(ADDR_TARGET, t);
    wr(ADDR_TARGET, u);
    check("csp no sync", {1'h0, p}, {1'h0, pos_demand});
    di = $signed(u - p);
    if (di < 0) di = -di;
    rdc("ferr", ADDR_STATUS, 32'h2000,
      di > int'(RST_FERR_WIN) ? 32'h2000 : 32'h0);
    sync_en <= 1'h1;
    for (int i = 0; i < 300 && pos_demand !== u; i++) @(posedge clk);
    check("csp pos", {1'h0, u}, {1'h0, pos_demand});
    rdc("csp follow", ADDR_STATUS, 32'h3100, 32'h1100);
    wr(ADDR_CTRL, 32'h100);
    wait_reg("csp halted", ADDR_STATUS, 32'h1000, 32'h0);
    wr(ADDR_CFG, 32'h2);
    wait_reg("csp unsynced", ADDR_STATUS, 32'h0100, 32'h0);
    $display("test cyclic done");
    tally_and_finish();
  end
endmodule : hcp_motion_tb
